// *** core/twl_eval.sv ***
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module twl_eval
    import twl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    // AXI4-Lite register slave
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Received telegrams and device events
    input  wire logic              INT_BRT_VALID,
    input  wire logic [15:0]       INT_BRT_DATA,
    input  wire logic              EXT_BRT_VALID,
    input  wire logic [15:0]       EXT_BRT_DATA,
    input  wire logic              PRESET_VALID,
    input  wire logic [15:0]       PRESET_DATA,
    input  wire logic              TEACH_VALID,
    input  wire logic              TEACH_VALUE,
    input  wire logic              IR_LVL_VALID,
    input  wire logic [15:0]       IR_LVL_DATA,
    input  wire logic              DEACT_VALID,
    input  wire logic              DEACT_VALUE,
    input  wire logic              CFG_DOWNLOAD,
    input  wire logic              BUS_RETURN,
    // Motion path of the function block
    input  wire logic              PIR_MOTION,
    input  wire logic              EXT_MOTION,
    input  wire logic              FB_IDLE,
    output logic                   MOTION_OK,
    output logic                   DET_START,
    output logic                   SWITCH_OFF,
    // Transmitted telegrams
    output logic                   LVL_TX_VALID,
    output logic [15:0]            LVL_TX_DATA,
    output logic                   MEAS_TX_VALID,
    output logic [15:0]            MEAS_TX_DATA
);

    initial begin
        if (TICK_CYCLES < 1 || TICK_CYCLES > 32768) begin
            $error("TICK_CYCLES out of range");
        end
    end

    localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] lvlcfg;
        logic [31:0] timing;
        logic [14:0] tick_cnt;
        logic [15:0] int_val;
        logic        int_vld;
        logic [15:0] ext_val;
        logic        ext_vld;
        logic        custom;
        logic [15:0] held;
        logic        deact;
        logic [15:0] last_lvl;
        logic        tx_pend;
        logic [7:0]  tx_cnt;
        twl_so_t     so_st;
        logic [7:0]  so_cnt;
        logic        motion_ok;
        logic        det_start;
        logic        switch_off;
        logic        lvl_tx_vld;
        logic [15:0] lvl_tx_data;
        logic        meas_vld;
        logic [15:0] meas_data;
    } twl_state_t;

    twl_state_t q;
    twl_state_t d;

    // 2-byte float: sign, 4-bit exponent, 11-bit mantissa, unit 0.01 lux
    function automatic logic [26:0] dpt_to_cl(input logic [15:0] v);
        logic [26:0] r;
        r = 27'(v[10:0]) << v[14:11];
        if (v[15]) begin
            r = '0;
        end
        return r;
    endfunction

    // Truncating encode; loses at most the shifted-out low bits
    function automatic logic [15:0] cl_to_dpt(input logic [26:0] c);
        logic [26:0] m;
        logic [3:0]  e;
        m = c;
        e = '0;
        for (int i = 0; i < 15; i++) begin
            if (m > MANT_MAX) begin
                m = m >> 1;
                e = e + 4'h1;
            end
        end
        return {1'b0, e, m[10:0]};
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [1:0]  src_sel;
    logic [1:0]  app;
    logic [1:0]  pol;
    logic [6:0]  wgt;
    logic [7:0]  so_pct;
    logic [7:0]  so_dly;
    logic [7:0]  tx_dly;
    logic        tick;
    logic [26:0] int_cl;
    logic [26:0] ext_cl;
    logic [26:0] eff_cl;
    logic        brt_vld;
    logic [33:0] wsum;
    logic [15:0] act_lvl;
    logic [26:0] lvl_cl;
    logic [26:0] thr_cl;
    logic        dep;
    logic        below;
    logic        blocked;
    logic        teach_act;

    always_comb begin
        d = q;
        d.awready    = 1'b0;
        d.wready     = 1'b0;
        d.arready    = 1'b0;
        d.motion_ok  = 1'b0;
        d.det_start  = 1'b0;
        d.switch_off = 1'b0;
        d.lvl_tx_vld = 1'b0;
        d.meas_vld   = 1'b0;

        src_sel = q.ctrl[CTRL_SRC_LSB +: 2];
        app     = q.ctrl[CTRL_APP_LSB +: 2];
        pol     = q.ctrl[CTRL_POL_LSB +: 2];
        wgt     = q.ctrl[CTRL_WGT_LSB +: 7];
        if (wgt > PCT_FULL) begin
            wgt = PCT_FULL;
        end
        so_pct  = q.timing[TIM_SOPCT_LSB +: 8];
        so_dly  = q.timing[TIM_SODLY_LSB +: 8];
        tx_dly  = q.timing[TIM_TXDLY_LSB +: 8];

        tick       = (q.tick_cnt == TICK_LAST);
        d.tick_cnt = tick ? '0 : q.tick_cnt + 15'h1;

        // Effective brightness
        int_cl = dpt_to_cl(q.int_val);
        ext_cl = dpt_to_cl(q.ext_val);
        wsum   = 34'(int_cl) * 34'(wgt) + 34'(ext_cl) * 34'(PCT_FULL - wgt);
        eff_cl  = int_cl;
        brt_vld = q.int_vld;
        case (src_sel)
            SRC_EXT: begin
                eff_cl  = ext_cl;
                brt_vld = q.ext_vld;
            end
            SRC_BOTH: begin
                brt_vld = q.int_vld | q.ext_vld;
                if (q.int_vld && q.ext_vld) begin
                    eff_cl = 27'(wsum / 34'(PCT_FULL));
                end else if (q.ext_vld) begin
                    eff_cl = ext_cl;
                end
            end
            default: begin
                eff_cl  = int_cl;
                brt_vld = q.int_vld;
            end
        endcase

        act_lvl = q.custom ? q.held : q.lvlcfg[15:0];
        lvl_cl  = dpt_to_cl(act_lvl);
        thr_cl  = 27'((34'(lvl_cl) * (34'(PCT_FULL) + 34'(so_pct))) / 34'(PCT_FULL));

        // Detector and light-control presence never evaluate brightness
        dep = q.ctrl[CTRL_DEP_BIT] && (app == APP_CEIL || app == APP_PRES)
              && !q.deact && brt_vld;
        below   = eff_cl < lvl_cl;
        blocked = (q.so_st != SO_IDLE);

        // Internal sensor sample and optional publication
        if (INT_BRT_VALID) begin
            d.int_val = INT_BRT_DATA;
            d.int_vld = 1'b1;
            if (q.ctrl[CTRL_MEAS_BIT]) begin
                d.meas_vld  = 1'b1;
                d.meas_data = INT_BRT_DATA;
            end
        end
        if (EXT_BRT_VALID) begin
            d.ext_val = EXT_BRT_DATA;
            d.ext_vld = 1'b1;
        end

        // Motion gating
        if (PIR_MOTION && !blocked && (!dep || below)) begin
            d.motion_ok = 1'b1;
        end
        if (EXT_MOTION && !blocked
            && (!dep || !q.ctrl[CTRL_EXTG_BIT] || below)) begin
            d.motion_ok = 1'b1;
        end
        d.det_start = d.motion_ok && FB_IDLE;

        if (DEACT_VALID) begin
            d.deact = DEACT_VALUE;
        end

        // Level sources; later ones win when they coincide.
        // No disable input exists here, so disabling cannot interfere.
        if (CFG_DOWNLOAD && q.ctrl[CTRL_OVW_BIT]) begin
            d.custom = 1'b0;
        end
        if (PRESET_VALID && q.ctrl[CTRL_PRE_BIT]) begin
            d.held   = PRESET_DATA;
            d.custom = 1'b1;
        end
        if (IR_LVL_VALID && q.ctrl[CTRL_FIRST_BIT]) begin
            d.held   = IR_LVL_DATA;
            d.custom = 1'b1;
        end
        teach_act = (pol == POL_BOTH) || (TEACH_VALUE == (pol == POL_ONE));
        if (TEACH_VALID && q.ctrl[CTRL_TEACH_BIT]) begin
            if (teach_act) begin
                if (brt_vld) begin
                    d.held   = cl_to_dpt(eff_cl);
                    d.custom = 1'b1;
                end
            end else begin
                d.custom = 1'b0;
            end
        end

        // Level reporting
        d.last_lvl = act_lvl;
        if (CFG_DOWNLOAD || BUS_RETURN) begin
            d.tx_pend = 1'b1;
            d.tx_cnt  = '0;
        end else if (q.tx_pend) begin
            if (q.tx_cnt >= tx_dly) begin
                d.tx_pend = 1'b0;
            end else if (tick) begin
                d.tx_cnt = q.tx_cnt + 8'h1;
            end
        end
        if (q.ctrl[CTRL_ACT_BIT]) begin
            if ((act_lvl != q.last_lvl)
                || (q.tx_pend && q.tx_cnt >= tx_dly && !CFG_DOWNLOAD && !BUS_RETURN)) begin
                d.lvl_tx_vld  = 1'b1;
                d.lvl_tx_data = act_lvl;
            end
        end

        // Presence switch-off on excess brightness
        case (q.so_st)
            SO_IDLE: begin
                if (app == APP_PRES && dep && !FB_IDLE && eff_cl > thr_cl) begin
                    d.so_st  = SO_WAIT;
                    d.so_cnt = '0;
                end
            end
            SO_WAIT: begin
                if (FB_IDLE || !dep) begin
                    d.so_st = SO_IDLE;
                end else if (q.so_cnt >= so_dly) begin
                    d.switch_off = 1'b1;
                    d.so_st      = SO_DONE;
                end else if (tick) begin
                    d.so_cnt = q.so_cnt + 8'h1;
                end
            end
            SO_DONE: begin
                if (FB_IDLE) begin
                    d.so_st = SO_IDLE;
                end
            end
            default: begin
                d.so_st = SO_IDLE;
            end
        endcase

        // AXI4-Lite write: address and data taken together
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid && !q.awready) begin
            d.awready = 1'b1;
            d.wready  = 1'b1;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            case (S_AXI_AWADDR)
                ADDR_CTRL:   d.ctrl   = strb_merge(q.ctrl, S_AXI_WDATA, S_AXI_WSTRB);
                ADDR_LVLCFG: d.lvlcfg = {16'h0000,
                                         strb_merge(q.lvlcfg, S_AXI_WDATA, S_AXI_WSTRB)
                                         [15:0]};
                ADDR_TIMING: d.timing = {8'h00,
                                         strb_merge(q.timing, S_AXI_WDATA, S_AXI_WSTRB)
                                         [23:0]};
                ADDR_STATUS, ADDR_EFFBRT: d.bresp = RESP_OKAY;
                default:     d.bresp  = RESP_SLVERR;
            endcase
        end

        // AXI4-Lite read
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && !q.rvalid && !q.arready) begin
            d.arready = 1'b1;
            d.rvalid  = 1'b1;
            d.rresp   = RESP_OKAY;
            d.rdata   = '0;
            case (S_AXI_ARADDR)
                ADDR_CTRL:   d.rdata = q.ctrl;
                ADDR_LVLCFG: d.rdata = q.lvlcfg;
                ADDR_TIMING: d.rdata = q.timing;
                ADDR_STATUS: begin
                    d.rdata[15:0]          = act_lvl;
                    d.rdata[ST_CUSTOM_BIT] = q.custom;
                    d.rdata[ST_INTV_BIT]   = q.int_vld;
                    d.rdata[ST_EXTV_BIT]   = q.ext_vld;
                    d.rdata[ST_DEP_BIT]    = dep;
                    d.rdata[ST_DEACT_BIT]  = q.deact;
                    d.rdata[ST_SOFF_BIT]   = blocked;
                end
                ADDR_EFFBRT: d.rdata[15:0] = cl_to_dpt(eff_cl);
                default:     d.rresp = RESP_SLVERR;
            endcase
        end
    end

    // Held level, custom flag and deactivation survive only a warm reset if
    // kept elsewhere; here reset clears them to the configured defaults.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q          <= '0;
            q.ctrl     <= CTRL_RST;
            q.lvlcfg   <= LVLCFG_RST;
            q.timing   <= TIMING_RST;
            q.last_lvl <= LVLCFG_RST[15:0];
            q.so_st    <= SO_IDLE;
        end else begin
            q <= d;
        end
    end

    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY  = q.wready;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RDATA   = q.rdata;
    assign S_AXI_RRESP   = q.rresp;
    assign S_AXI_RVALID  = q.rvalid;
    assign MOTION_OK     = q.motion_ok;
    assign DET_START     = q.det_start;
    assign SWITCH_OFF    = q.switch_off;
    assign LVL_TX_VALID  = q.lvl_tx_vld;
    assign LVL_TX_DATA   = q.lvl_tx_data;
    assign MEAS_TX_VALID = q.meas_vld;
    assign MEAS_TX_DATA  = q.meas_data;

endmodule

// *** core/twl_pkg.sv ***
package twl_pkg;

    // Timing base for the configurable delays
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register map
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_LVLCFG = 8'h04;
    localparam logic [7:0]  ADDR_TIMING = 8'h08;
    localparam logic [7:0]  ADDR_STATUS = 8'h0c;
    localparam logic [7:0]  ADDR_EFFBRT = 8'h10;

    // Control register fields
    localparam int CTRL_SRC_LSB   = 0;
    localparam int CTRL_APP_LSB   = 2;
    localparam int CTRL_DEP_BIT   = 4;
    localparam int CTRL_FIRST_BIT = 5;
    localparam int CTRL_EXTG_BIT  = 6;
    localparam int CTRL_ACT_BIT   = 7;
    localparam int CTRL_TEACH_BIT = 8;
    localparam int CTRL_POL_LSB   = 9;
    localparam int CTRL_PRE_BIT   = 11;
    localparam int CTRL_OVW_BIT   = 12;
    localparam int CTRL_MEAS_BIT  = 13;
    localparam int CTRL_WGT_LSB   = 16;

    // Timing register fields
    localparam int TIM_SOPCT_LSB = 0;
    localparam int TIM_SODLY_LSB = 8;
    localparam int TIM_TXDLY_LSB = 16;

    // Status register fields
    localparam int ST_CUSTOM_BIT = 16;
    localparam int ST_INTV_BIT   = 17;
    localparam int ST_EXTV_BIT   = 18;
    localparam int ST_DEP_BIT    = 19;
    localparam int ST_DEACT_BIT  = 20;
    localparam int ST_SOFF_BIT   = 21;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0032_0000;
    localparam logic [31:0] LVLCFG_RST = 32'h0000_24e2;
    localparam logic [31:0] TIMING_RST = 32'h0000_0a14;

    // Encodings
    localparam logic [1:0] SRC_INT     = 2'h0;
    localparam logic [1:0] SRC_EXT     = 2'h1;
    localparam logic [1:0] SRC_BOTH    = 2'h2;
    localparam logic [1:0] APP_DET     = 2'h0;
    localparam logic [1:0] APP_CEIL    = 2'h1;
    localparam logic [1:0] APP_PRES    = 2'h2;
    localparam logic [1:0] APP_PRES_LC = 2'h3;
    localparam logic [1:0] POL_ONE     = 2'h0;
    localparam logic [1:0] POL_ZERO    = 2'h1;
    localparam logic [1:0] POL_BOTH    = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Arithmetic constants
    localparam logic [26:0] MANT_MAX = 27'h00007ff;
    localparam logic [6:0]  PCT_FULL = 7'h64;

    typedef enum logic [1:0] {
        SO_IDLE = 2'b00,
        SO_WAIT = 2'b01,
        SO_DONE = 2'b10
    } twl_so_t;

endpackage

// *** dv/twl_eval_sva.sv ***
`timescale 1ns/1ps
module twl_eval_sva (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // Register bus
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // Motion path
    input wire logic        PIR_MOTION,
    input wire logic        EXT_MOTION,
    input wire logic        FB_IDLE,
    input wire logic        MOTION_OK,
    input wire logic        DET_START,
    input wire logic        SWITCH_OFF
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
        && !S_AXI_AWREADY |=> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID)
        else $error("write not answered");
    a_aw_single: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("awready too long");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bvalid dropped");
    a_rd_answer: assert property (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY
        |=> S_AXI_ARREADY && S_AXI_RVALID) else $error("read not answered");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rvalid dropped");
    a_ok_cause: assert property (
        MOTION_OK |-> $past(PIR_MOTION || EXT_MOTION)) else $error("motion without cause");
    a_det_idle: assert property (
        DET_START |-> MOTION_OK && $past(FB_IDLE)) else $error("start while busy");
    a_det_start: assert property (
        MOTION_OK && $past(FB_IDLE) |-> DET_START) else $error("idle motion not started");
    a_off_pulse: assert property (
        SWITCH_OFF |=> !SWITCH_OFF) else $error("switch-off not a pulse");
endmodule

bind twl_eval twl_eval_sva u_sva (
    .CLK(CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .PIR_MOTION(PIR_MOTION), .EXT_MOTION(EXT_MOTION),
    .FB_IDLE(FB_IDLE), .MOTION_OK(MOTION_OK), .DET_START(DET_START), .SWITCH_OFF(SWITCH_OFF)
);

// *** dv/twl_bus_partner.sv ***
`timescale 1ns/1ps
module twl_bus_partner (
    // Clock
    input  wire logic        clk,
    // Telegrams to the device
    output logic             ext_brt_valid,
    output logic [15:0]      ext_brt_data,
    output logic             preset_valid,
    output logic [15:0]      preset_data,
    output logic             teach_valid,
    output logic             teach_value,
    output logic             deact_valid,
    output logic             deact_value,
    output logic             ext_motion,
    // Level telegrams from the device
    input  wire logic        lvl_tx_valid,
    input  wire logic [15:0] lvl_tx_data
);
    logic [4:0]  vld      = 5'h00;
    logic [15:0] dat      = 16'h0000;
    logic [15:0] last_lvl = 16'h0000;
    int          lvl_cnt  = 0;
    assign {ext_motion, deact_valid, teach_valid, preset_valid, ext_brt_valid} = vld;
    assign ext_brt_data = dat;
    assign preset_data = dat;
    assign teach_value = dat[0];
    assign deact_value = dat[0];
    // Kind: 0 brightness, 1 preset, 2 teach, 3 deactivate, 4 motion
    task send(input logic [2:0] k, input logic [15:0] d);
        @(posedge clk);
        vld <= 5'h01 << k;
        dat <= d;
        @(posedge clk);
        vld <= 5'h00;
        // Inverted after the pulse so a stale value never passes for a fresh one
        dat <= ~d;
    endtask
    always @(posedge clk) begin
        if (lvl_tx_valid) begin
            last_lvl <= lvl_tx_data;
            lvl_cnt <= lvl_cnt + 1;
        end
    end
endmodule

// *** dv/twl_eval_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module twl_eval_test import twl_pkg::*;;
    localparam logic [31:0] BASE = 32'h003209f9;
    logic        clk = 1'b0, rst_n = 1'b0, pir = 1'b0, idle = 1'b1, ir_v = 1'b0, dl = 1'b0;
    logic        iv = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd_v;
    logic [15:0] ir_d = 16'h0, id = 16'h0;
    logic [1:0]  rs;
    wire logic   awready, wready, bvalid, arready, rvalid, ok, det, lvl_v, ebv, pv, tv, tval;
    wire logic   dv, dval, em, sw, mv;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] lvl_d, ebd, pd, md;
    int          mismatches = 0, num_checks = 0, cyc = 0, c, n_off = 0;
    twl_eval #(.TICK_CYCLES(4)) DUT (.CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .INT_BRT_VALID(iv), .INT_BRT_DATA(id), .EXT_BRT_VALID(ebv), .EXT_BRT_DATA(ebd),
        .PRESET_VALID(pv), .PRESET_DATA(pd), .TEACH_VALID(tv), .TEACH_VALUE(tval),
        .IR_LVL_VALID(ir_v), .IR_LVL_DATA(ir_d), .DEACT_VALID(dv), .DEACT_VALUE(dval),
        .CFG_DOWNLOAD(dl), .BUS_RETURN(1'b0), .PIR_MOTION(pir), .EXT_MOTION(em),
        .FB_IDLE(idle), .MOTION_OK(ok), .DET_START(det), .SWITCH_OFF(sw),
        .LVL_TX_VALID(lvl_v), .LVL_TX_DATA(lvl_d), .MEAS_TX_VALID(mv), .MEAS_TX_DATA(md));
    twl_bus_partner P (.clk(clk), .ext_brt_valid(ebv), .ext_brt_data(ebd), .preset_valid(pv),
        .preset_data(pd), .teach_valid(tv), .teach_value(tval), .deact_valid(dv),
        .deact_value(dval), .ext_motion(em), .lvl_tx_valid(lvl_v), .lvl_tx_data(lvl_d));
    initial begin
        forever #20 clk = ~clk;
    end
    task complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (sw) n_off++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awready) {awvalid, wvalid} <= 2'h0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task mot(input logic x, input logic i, input logic ex, input string n);
        if (x) begin
            idle <= i;
            P.send(3'h4, 16'h0001);
        end else begin
            @(posedge clk);
            idle <= i;
            pir <= 1'b1;
            @(posedge clk);
            pir <= 1'b0;
        end
        #1;
        `CHK(n, ex, ok)
        `CHK(n, ex & i, det)
    endtask
    task ev(input logic ir, input logic [15:0] d);
        @(posedge clk);
        ir_v <= ir;
        ir_d <= d;
        dl <= !ir;
        @(posedge clk);
        {ir_v, dl} <= 2'h0;
        ir_d <= ~d;
    endtask
    task lvl(input logic [15:0] x, input string n);
        rd(ADDR_STATUS);
        `CHK(n, x, rd_v[15:0])
    endtask
    task t_regs;
        rd(ADDR_CTRL);
        `CHK("ctrl", CTRL_RST, rd_v)
        rd(ADDR_LVLCFG);
        `CHK("lvlcfg", LVLCFG_RST, rd_v)
        rd(ADDR_TIMING);
        `CHK("timing", TIMING_RST, rd_v)
        rd(8'h14);
        `CHK("rd_unmap", RESP_SLVERR, rs)
        wr(8'h14, 32'hffffffff);
        `CHK("wr_unmap", RESP_SLVERR, rs)
    endtask
    task t_motion;
        wr(ADDR_CTRL, BASE);
        mot(0, 1, 1, "no_ext");
        P.send(3'h0, 16'h0064);
        mot(0, 1, 1, "dark");
        mot(0, 0, 1, "busy");
        P.send(3'h0, 16'h24e2);
        mot(0, 1, 0, "equal");
        P.send(3'h0, 16'h7fff);
        mot(1, 1, 0, "ext_gate");
        P.send(3'h3, 16'h0001);
        mot(0, 1, 1, "deact");
        mot(1, 1, 1, "deact_ext");
        P.send(3'h3, 16'h0000);
        mot(0, 1, 0, "react");
        wr(ADDR_CTRL, BASE & ~32'h40);
        mot(1, 1, 1, "ext_free");
        wr(ADDR_CTRL, BASE & ~32'hc);
        mot(0, 1, 1, "detector");
        wr(ADDR_CTRL, BASE | 32'h4);
        mot(0, 1, 1, "light_ctrl");
    endtask
    task t_level;
        wr(ADDR_CTRL, BASE);
        P.send(3'h1, 16'h0c80);
        lvl(16'h0c80, "preset");
        `CHK("lvl_tx", 16'h0c80, P.last_lvl)
        c = P.lvl_cnt;
        ev(0, 16'h0);
        lvl(16'h0c80, "dl_keep");
        `CHK("dl_tx", c + 1, P.lvl_cnt)
        P.send(3'h0, 16'h0064);
        P.send(3'h2, 16'h0001);
        rd(ADDR_EFFBRT);
        `CHK("effbrt_ext", 16'h0064, rd_v[15:0])
        lvl(16'h0064, "teach");
        P.send(3'h2, 16'h0000);
        lvl(LVLCFG_RST[15:0], "untaught");
        `CHK("custom", 1'b0, rd_v[ST_CUSTOM_BIT])
        wr(ADDR_CTRL, BASE | 32'h400);
        P.send(3'h2, 16'h0000);
        lvl(16'h0064, "both_pol");
        ev(1, 16'h1000);
        lvl(16'h1000, "ir_first");
        wr(ADDR_CTRL, BASE & ~32'h20);
        ev(1, 16'h2000);
        lvl(16'h1000, "ir_other");
        wr(ADDR_CTRL, BASE | 32'h1000);
        ev(0, 16'h0);
        lvl(LVLCFG_RST[15:0], "dl_ovw");
    endtask
    task t_mix;
        wr(ADDR_CTRL, (BASE & ~32'h1) | 32'h2002);
        rd(ADDR_EFFBRT);
        `CHK("eff_single", 16'h0064, rd_v[15:0])
        @(posedge clk);
        iv <= 1'b1;
        id <= 16'h012c;
        @(posedge clk);
        iv <= 1'b0;
        #1;
        `CHK("meas_vld", 1'b1, mv)
        `CHK("meas_data", 16'h012c, md)
        rd(ADDR_EFFBRT);
        `CHK("eff_weight", 16'h00c8, rd_v[15:0])
    endtask
    task t_off;
        wr(ADDR_CTRL, BASE);
        P.send(3'h0, 16'h7fff);
        @(posedge clk);
        idle <= 1'b0;
        c = 0;
        while (n_off == 0 && c < 100) begin
            @(posedge clk);
            c++;
        end
        `CHK("off_count", 1, n_off)
        mot(0, 0, 0, "off_block");
        idle <= 1'b1;
        P.send(3'h3, 16'h0001);
        idle <= 1'b0;
        repeat (80) @(posedge clk);
        `CHK("off_deact", 1, n_off)
        idle <= 1'b1;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_motion();
        t_level();
        t_mix();
        t_off();
        complete_run();
    end
endmodule
